// ---- hdl/exception_priority_vector_map.sv ----
// Exception prioritiser and vector map with a classic Wishbone slave.
// Assumes synchronous fault/request strobes from the core's clock domain.
// Function
// - Eight settable levels for seven system handlers and 23 interrupts.
// - Settable level 0 ranks fourth, below reset, NMI and hard fault.
// - All settable priority fields reset to 0.
// - Equal levels resolve to lower position number first.
// - Reset vector 1, level -3; drops to base on first instruction.
// - NMI vector 2, level -2; only reset can preempt it.
// - NMI raised only by software control register write.
// - Hard fault vector 3, level -1; blocked faults escalate to it.
// - Memory protection mismatch raises vector 4, settable level.
// - Bus fault vector 5, settable; precise and imprecise sources.
// - Bus fault individually enabled by software.
// - Usage fault raises vector 6, settable level.
// - Service call raises vector 11, settable level.
// - Debug monitor vector 12, enabled only, no lower-priority activation.
// - Pendable service vector 14, settable, software pended only.
// - Tick event raises vector 15, settable level.
// - Interrupt numbers map to the listed peripheral sources.
// - State stacked with parallel vector fetch; restored at handler end.
// - Pending handler at completion tail-chains without restore.
// - Priority split into group and subpriority; group alone preempts.
// - Initial stack pointer loaded from vector table entry 0.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module exception_priority_vector_map (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic [47:0] irqPins,
	input  wire logic        memFault,
	input  wire logic        busFaultPrecise,
	input  wire logic        busFaultImprecise,
	input  wire logic        usageFault,
	input  wire logic        serviceCall,
	input  wire logic        debugMonitor,
	input  wire logic        tickEvent,
	input  wire logic        firstInstr,
	input  wire logic        stackDone,
	input  wire logic        handlerDone,
	output logic             loadStack,
	output logic             stackSave,
	output logic             stateRestore,
	output logic             vecFetch,
	output logic [5:0]       vecNum,
	output logic [4:0]       activeLvl
);
	localparam int N = evm_pkg::NUM_IRQ;
	localparam int PW = evm_pkg::PRIO_W;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second
	logic [N-1:0] irqS1_ff, irqS2_ff;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irqS1_ff <= '0;
			irqS2_ff <= '0;
		end else begin
			irqS1_ff <= irqPins;
			irqS2_ff <= irqS1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0]   ctrl_ff, nxt_ctrl;
	logic [PW-1:0] shp_ff [7], nxt_shp [7];
	logic [PW-1:0] ipr_ff [N], nxt_ipr [N];
	logic [N-1:0]  ien_ff, nxt_ien;
	logic [N-1:0]  ipend_ff, nxt_ipend;
	logic [6:0]    spend_ff, nxt_spend;
	logic          nmiPend_ff, nxt_nmiPend;
	logic          hardPend_ff, nxt_hardPend;
	logic          ack_ff, nxt_ack;
	logic [31:0]   rdat_ff, nxt_rdat;
	logic [4:0]    act_ff, nxt_act;
	logic [5:0]    vec_ff, nxt_vec;
	evm_pkg::core_e st_ff, nxt_st;
	logic          boot_ff, nxt_boot;
	logic          take, wr;
	logic [7:0]    adr;
	logic [2:0]    grp;
	evm_pkg::pick_s best;
	logic [6:0]    sysIn;
	logic          escalate;
	logic [3:0]    blocked;
	evm_pkg::pick_s entry, grant;
	logic          chain_ff, nxt_chain;

	assign adr  = wb_adr_i[7:0];
	assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
	// Writes land on the edge at which the master sees ack
	assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
	assign grp  = ctrl_ff[evm_pkg::C_GRP +: 3];

	// Group-only compare: low grp bits are subpriority
	function automatic logic [4:0] grpOf(input logic [4:0] l,
			input logic [2:0] g);
		logic [4:0] m;
		m = 5'h07 << g;
		// Fixed ranks and base pass through; only the settable part splits
		if (l < evm_pkg::LVL_SET0 || l == evm_pkg::LVL_BASE) grpOf = l;
		else grpOf = evm_pkg::LVL_SET0
			+ ((l - evm_pkg::LVL_SET0) & m);
	endfunction

	function automatic logic [4:0] lvlOf(input logic [PW-1:0] p);
		lvlOf = evm_pkg::LVL_SET0 + {2'h0, p};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pending and priority selection
	// Order sys: mem,bus,usage,svc,dbg,psv,tick
	localparam logic [5:0] SVEC [7] = '{evm_pkg::VEC_MEM, evm_pkg::VEC_BUS,
		evm_pkg::VEC_USAGE, evm_pkg::VEC_SVC, evm_pkg::VEC_DBG,
		evm_pkg::VEC_PSV, evm_pkg::VEC_TICK};

	always_comb begin
		logic [4:0] l;
		logic [4:0] now;
		l = '0;
		now = grpOf(act_ff, grp);
		// A mem, precise bus, usage or svc event that cannot preempt the active level escalates instead
		blocked[0] = now <= grpOf(lvlOf(shp_ff[0]), grp);
		blocked[1] = now <= grpOf(lvlOf(shp_ff[1]), grp);
		blocked[2] = now <= grpOf(lvlOf(shp_ff[2]), grp);
		blocked[3] = now <= grpOf(lvlOf(shp_ff[3]), grp);
		escalate = (busFaultPrecise
			& (~ctrl_ff[evm_pkg::C_BUSE] | blocked[1]))
			| (memFault & blocked[0])
			| (usageFault & blocked[2])
			| (serviceCall & blocked[3]);
		sysIn[6] = tickEvent;
		sysIn[5] = 1'b0;
		sysIn[4] = debugMonitor & ctrl_ff[evm_pkg::C_DBGE];
		sysIn[3] = serviceCall & ~blocked[3];
		sysIn[2] = usageFault & ~blocked[2];
		// Imprecise bus faults are asynchronous, so they wait as pending
		sysIn[1] = ctrl_ff[evm_pkg::C_BUSE]
			& ((busFaultPrecise & ~blocked[1]) | busFaultImprecise);
		sysIn[0] = memFault & ~blocked[0];
		best = '{valid: 1'b0, vec: 6'h00, lvl: evm_pkg::LVL_BASE};
		if (nmiPend_ff) begin
			best = '{valid: 1'b1, vec: evm_pkg::VEC_NMI,
				lvl: evm_pkg::LVL_NMI};
		end else if (hardPend_ff) begin
			best = '{valid: 1'b1, vec: evm_pkg::VEC_HARD,
				lvl: evm_pkg::LVL_HARD};
		end else begin
			// Strict less-than keeps the lowest position on ties
			for (int i = 0; i < 7; i++) begin
				l = lvlOf(shp_ff[i]);
				if (spend_ff[i] && l < best.lvl) begin
					best = '{valid: 1'b1, vec: SVEC[i], lvl: l};
				end
			end
			for (int i = 0; i < N; i++) begin
				l = lvlOf(ipr_ff[i]);
				if (ipend_ff[i] && ien_ff[i] && l < best.lvl) begin
					best = '{valid: 1'b1,
						vec: evm_pkg::VEC_IRQ0 + 6'(i), lvl: l};
				end
			end
		end
		// Preempt only on strictly more urgent group
		entry = best;
		if (best.valid && grpOf(best.lvl, grp) >= now) begin
			entry.valid = 1'b0;
		end
		// At handler end the level returns to base, so any pending chains
		grant = '{valid: 1'b0, vec: 6'h00, lvl: evm_pkg::LVL_BASE};
		if (st_ff == evm_pkg::ST_RUN && !boot_ff) begin
			grant = entry;
		end else if (st_ff == evm_pkg::ST_SERV && handlerDone) begin
			grant = best;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register next state and core sequencer
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_shp = shp_ff;
		nxt_ipr = ipr_ff;
		nxt_ien = ien_ff;
		nxt_ack = take;
		nxt_rdat = rdat_ff;
		nxt_nmiPend = nmiPend_ff;
		nxt_hardPend = hardPend_ff | escalate;
		nxt_spend = spend_ff;
		nxt_ipend = ipend_ff | (irqS2_ff & evm_pkg::IRQ_IMPL);
		nxt_act = act_ff;
		nxt_vec = vec_ff;
		nxt_st = st_ff;
		nxt_boot = boot_ff;
		nxt_chain = 1'b0;
		if (take) begin
			nxt_rdat = 32'h0;
			unique case (adr)
				evm_pkg::A_CTRL: nxt_rdat = {25'h0, ctrl_ff[6:2], 2'h0};
				evm_pkg::A_STAT: nxt_rdat = {15'h0, st_ff, vec_ff,
					act_ff, nmiPend_ff, hardPend_ff, 1'b0, spend_ff[5]};
				evm_pkg::A_SHPR: for (int i = 0; i < 7; i++)
					nxt_rdat[4*i +: PW] = shp_ff[i];
				evm_pkg::A_IEN0: nxt_rdat = ien_ff[31:0];
				evm_pkg::A_IEN1: nxt_rdat = {16'h0, ien_ff[47:32]};
				default: begin
					for (int r = 0; r < 6; r++)
						if (adr == evm_pkg::A_IPR0 + 8'(4*r))
							for (int j = 0; j < 8; j++)
								nxt_rdat[4*j +: PW] = ipr_ff[8*r+j];
				end
			endcase
		end
		if (wr && wb_sel_i[0]) begin
			unique case (adr)
				evm_pkg::A_CTRL: begin
					nxt_ctrl[6:2] = wb_dat_i[6:2];
					if (wb_dat_i[evm_pkg::C_NMI]) nxt_nmiPend = 1'b1;
					if (wb_dat_i[evm_pkg::C_PSV]) nxt_spend[5] = 1'b1;
				end
				default: ;
			endcase
		end
		if (wr) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					for (int h = 0; h < 2; h++) begin
						if (adr == evm_pkg::A_SHPR && 2*b+h < 7)
							nxt_shp[2*b+h] = wb_dat_i[8*b+4*h +: PW];
						for (int r = 0; r < 6; r++)
							if (adr == evm_pkg::A_IPR0 + 8'(4*r))
								nxt_ipr[8*r+2*b+h] =
									wb_dat_i[8*b+4*h +: PW];
					end
					if (adr == evm_pkg::A_IEN0)
						nxt_ien[8*b +: 8] = wb_dat_i[8*b +: 8];
					if (adr == evm_pkg::A_IEN1 && b < 2)
						nxt_ien[32+8*b +: 8] = wb_dat_i[8*b +: 8];
				end
			end
			nxt_ien = nxt_ien & evm_pkg::IRQ_IMPL;
		end
		unique case (st_ff)
			evm_pkg::ST_RUN: begin
				if (boot_ff && firstInstr) begin
					nxt_boot = 1'b0;
					nxt_act = evm_pkg::LVL_BASE;
				end else if (!boot_ff && grant.valid) begin
					nxt_st = evm_pkg::ST_STACK;
					nxt_vec = grant.vec;
					nxt_act = grant.lvl;
				end
			end
			evm_pkg::ST_STACK: begin
				if (stackDone) nxt_st = evm_pkg::ST_SERV;
			end
			evm_pkg::ST_SERV: begin
				if (handlerDone && grant.valid) begin
					// Tail-chain: new vector, no restore and no re-stack
					nxt_vec = grant.vec;
					nxt_act = grant.lvl;
					nxt_chain = 1'b1;
				end else if (handlerDone) begin
					nxt_act = evm_pkg::LVL_BASE;
					nxt_st = evm_pkg::ST_RUN;
				end
			end
			default: nxt_st = evm_pkg::ST_RUN;
		endcase
		// Clear pending when taken; new events this cycle win over the clear
		if (grant.valid) begin
			if (grant.vec == evm_pkg::VEC_NMI) nxt_nmiPend = wr & wb_sel_i[0]
				& wb_dat_i[evm_pkg::C_NMI] & (adr == evm_pkg::A_CTRL);
			else if (grant.vec == evm_pkg::VEC_HARD) nxt_hardPend = escalate;
			else if (grant.vec >= evm_pkg::VEC_IRQ0)
				nxt_ipend[grant.vec - evm_pkg::VEC_IRQ0] =
					irqS2_ff[grant.vec - evm_pkg::VEC_IRQ0];
			else for (int i = 0; i < 7; i++)
				if (SVEC[i] == grant.vec)
					nxt_spend[i] = sysIn[i] | (i == 5 && wr
						&& adr == evm_pkg::A_CTRL && wb_sel_i[0]
						&& wb_dat_i[evm_pkg::C_PSV]);
		end
		nxt_spend = nxt_spend | sysIn;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= {25'h0, evm_pkg::GRP_RST, 4'h0};
			for (int i = 0; i < 7; i++) shp_ff[i] <= evm_pkg::PRIO_RST;
			for (int i = 0; i < N; i++) ipr_ff[i] <= evm_pkg::PRIO_RST;
			ien_ff <= '0;
			ipend_ff <= '0;
			spend_ff <= '0;
			nmiPend_ff <= 1'b0;
			hardPend_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdat_ff <= '0;
			act_ff <= evm_pkg::LVL_RESET;
			vec_ff <= evm_pkg::VEC_RESET;
			st_ff <= evm_pkg::ST_RUN;
			boot_ff <= 1'b1;
			chain_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			shp_ff <= nxt_shp;
			ipr_ff <= nxt_ipr;
			ien_ff <= nxt_ien;
			ipend_ff <= nxt_ipend;
			spend_ff <= nxt_spend;
			nmiPend_ff <= nxt_nmiPend;
			hardPend_ff <= nxt_hardPend;
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
			act_ff <= nxt_act;
			vec_ff <= nxt_vec;
			st_ff <= nxt_st;
			boot_ff <= nxt_boot;
			chain_ff <= nxt_chain;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_ack_o  = ack_ff;
	assign wb_dat_o  = rdat_ff;
	assign loadStack = boot_ff;
	// Vector fetch runs alongside stacking
	assign stackSave = st_ff == evm_pkg::ST_STACK;
	// A chained entry fetches its vector for one cycle without stacking
	assign vecFetch  = boot_ff | stackSave | chain_ff;
	// Restore only when nothing is waiting; else tail-chain
	assign stateRestore = st_ff == evm_pkg::ST_SERV && handlerDone
		&& !grant.valid;
	assign vecNum    = boot_ff ? evm_pkg::VEC_STACK : vec_ff;
	assign activeLvl = act_ff;
endmodule // exception_priority_vector_map

// ---- hdl/evm_pkg.sv ----
// Constants and carriers for the exception priority and vector map.
// Assumes a single system clock; core handshake is level based.
package evm_pkg;
	localparam int NUM_IRQ      = 48;
	localparam int PRIO_W       = 3;
	localparam int VEC_W        = 6;
	localparam int LVL_W        = 5;
	localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
	localparam logic [2:0]  GRP_RST    = 3'h0;
	localparam logic [47:0] IRQ_IMPL   = 48'h0000_3ffc_1cff;
	localparam logic [VEC_W-1:0] VEC_STACK = 6'h00;
	localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
	localparam logic [VEC_W-1:0] VEC_NMI   = 6'h02;
	localparam logic [VEC_W-1:0] VEC_HARD  = 6'h03;
	localparam logic [VEC_W-1:0] VEC_MEM   = 6'h04;
	localparam logic [VEC_W-1:0] VEC_BUS   = 6'h05;
	localparam logic [VEC_W-1:0] VEC_USAGE = 6'h06;
	localparam logic [VEC_W-1:0] VEC_SVC   = 6'h0b;
	localparam logic [VEC_W-1:0] VEC_DBG   = 6'h0c;
	localparam logic [VEC_W-1:0] VEC_PSV   = 6'h0e;
	localparam logic [VEC_W-1:0] VEC_TICK  = 6'h0f;
	localparam logic [VEC_W-1:0] VEC_IRQ0  = 6'h10;
	// Internal rank: 0 reset, 1 nmi, 2 hard, 4+prio settable, 31 base
	localparam logic [LVL_W-1:0] LVL_RESET = 5'h00;
	localparam logic [LVL_W-1:0] LVL_NMI   = 5'h01;
	localparam logic [LVL_W-1:0] LVL_HARD  = 5'h02;
	localparam logic [LVL_W-1:0] LVL_SET0  = 5'h04;
	localparam logic [LVL_W-1:0] LVL_BASE  = 5'h1f;
	// Register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STAT   = 8'h04;
	localparam logic [7:0] A_SHPR   = 8'h08;
	localparam logic [7:0] A_IEN0   = 8'h10;
	localparam logic [7:0] A_IEN1   = 8'h14;
	localparam logic [7:0] A_IPR0   = 8'h20;
	// CTRL fields
	localparam int C_NMI  = 0;
	localparam int C_PSV  = 1;
	localparam int C_BUSE = 2;
	localparam int C_DBGE = 3;
	localparam int C_GRP  = 4;
	typedef struct packed {
		logic             valid;
		logic [VEC_W-1:0] vec;
		logic [LVL_W-1:0] lvl;
	} pick_s;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_STACK = 2'b01,
		ST_SERV  = 2'b10
	} core_e;
endpackage

// ---- verif/exception_priority_vector_map_chk.sv ----
// Checker for the prioritiser's boot, entry and bus handshakes.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module exception_priority_vector_map_chk (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       firstInstr,
	input wire logic       handlerDone,
	input wire logic       loadStack,
	input wire logic       stackSave,
	input wire logic       stateRestore,
	input wire logic       vecFetch,
	input wire logic [5:0] vecNum,
	input wire logic [4:0] activeLvl
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence sTake;
		$rose(stackSave) ##0 vecFetch;
	endsequence
	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("bus request not answered");
	a_boot_vector: assert property (loadStack |-> vecNum == 6'h00
		&& activeLvl == evm_pkg::LVL_RESET) else $error("bad boot fetch");
	a_boot_end: assert property (firstInstr && loadStack |=>
		!loadStack && activeLvl == 5'h1f) else $error("boot not ended");
	a_fetch_parallel: assert property (stackSave |-> vecFetch)
		else $error("stacking without vector fetch");
	a_restore_cause: assert property (stateRestore |-> handlerDone)
		else $error("restore without handler end");
	a_nmi_rank: assert property (sTake ##0 vecNum == 6'h02 |->
		activeLvl == evm_pkg::LVL_NMI) else $error("nmi rank wrong");
	a_hard_rank: assert property (sTake ##0 vecNum == 6'h03 |->
		activeLvl == evm_pkg::LVL_HARD) else $error("hard rank wrong");
	a_set_rank: assert property (sTake ##0 vecNum >= 6'h04 |->
		activeLvl >= 5'h04 && activeLvl <= 5'h0b) else $error("bad rank");
	a_tail_chain: assert property (handlerDone && !stateRestore |=>
		vecFetch && !stackSave) else $error("tail chain restacked");
	a_no_reserved: assert property (vecFetch |-> !(vecNum inside
		{[6'h07:6'h0a], 6'h0d, 6'h18, 6'h19, [6'h1d:6'h21], [6'h2e:6'h3f]}))
		else $error("reserved vector taken");
endmodule // exception_priority_vector_map_chk

bind exception_priority_vector_map exception_priority_vector_map_chk chk (
	.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .firstInstr,
	.handlerDone, .loadStack, .stackSave, .stateRestore, .vecFetch,
	.vecNum, .activeLvl);

// ---- verif/core_model.sv ----
// Processor core stand-in: boots, then stacks and runs handlers.
// Assumes the prioritiser's stacking and restore handshakes.
`timescale 1ns/1ps
module core_model #(
	parameter int STACK_DLY = 2,
	parameter int SERVE_DLY = 4
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic stackSave,
	input  wire logic stateRestore,
	output logic      firstInstr,
	output logic      stackDone,
	output logic      handlerDone
);
	logic chain;
	initial begin
		firstInstr = 1'b0;
		stackDone = 1'b0;
		handlerDone = 1'b0;
		@(negedge rst);
		repeat (3) @(posedge mclk);
		firstInstr <= 1'b1;
		@(posedge mclk);
		firstInstr <= 1'b0;
		forever begin
			@(posedge mclk);
			if (stackSave) begin
				repeat (STACK_DLY) @(posedge mclk);
				stackDone <= 1'b1;
				@(posedge mclk);
				stackDone <= 1'b0;
				chain = 1'b1;
				while (chain) begin
					repeat (SERVE_DLY) @(posedge mclk);
					handlerDone <= 1'b1;
					@(negedge mclk);
					chain = !stateRestore;
					@(posedge mclk);
					handlerDone <= 1'b0;
					// A chained entry that stacks again is caught above
					@(negedge mclk);
					if (stackSave) chain = 1'b0;
				end
			end
		end
	end
endmodule // core_model

// ---- verif/exception_priority_vector_map_test.sv ----
// Self-checking bench for the exception prioritiser and vector map.
// Assumes the core model as partner and a Wishbone master task here.
`timescale 1ns/1ps
module exception_priority_vector_map_test;
	localparam int NROW = 13;
	logic        mclk, rst, wbCyc, wbWe, wbAck;
	logic [31:0] wbAdr, wbDatW, wbDatR;
	logic [47:0] irqPins;
	logic [6:0]  flt;
	logic        firstInstr, stackDone, handlerDone, loadStack, stackSave;
	logic        stateRestore, vecFetch;
	logic [5:0]  vecNum;
	logic [4:0]  activeLvl;
	logic [5:0]  served[$];
	int          error_cnt, compares, restoreCnt;
	int          rowSrc [NROW] = '{0, 7, 10, 29, 48, 49, 50, 51, 52, 53, 54,
		56, 57};
	logic [5:0]  rowVec [NROW] = '{6'h10, 6'h17, 6'h1a, 6'h2d, 6'h04, 6'h05,
		6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0f, 6'h02, 6'h0e};
	exception_priority_vector_map uut (.mclk(mclk), .rst(rst),
		.wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
		.wb_we_i(wbWe), .wb_sel_i(4'hf), .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc),
		.wb_ack_o(wbAck), .irqPins(irqPins), .memFault(flt[0]),
		.busFaultPrecise(flt[1]), .busFaultImprecise(flt[2]),
		.usageFault(flt[3]), .serviceCall(flt[4]), .debugMonitor(flt[5]),
		.tickEvent(flt[6]), .firstInstr(firstInstr), .stackDone(stackDone),
		.handlerDone(handlerDone), .loadStack(loadStack),
		.stackSave(stackSave), .stateRestore(stateRestore),
		.vecFetch(vecFetch), .vecNum(vecNum), .activeLvl(activeLvl));
	core_model core (.mclk(mclk), .rst(rst), .stackSave(stackSave),
		.stateRestore(stateRestore), .firstInstr(firstInstr),
		.stackDone(stackDone), .handlerDone(handlerDone));
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		if (handlerDone === 1'b1) served.push_back(vecNum);
		if (stateRestore === 1'b1) restoreCnt++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic miss(input string s);
		error_cnt++;
		$display("mismatch at %0t: %s", $time, s);
	endtask
	task automatic chkReg(input logic [31:0] got, exp, input string s);
		compares++;
		if (got !== exp) miss($sformatf("%s %h not %h", s, got, exp));
	endtask
	task automatic chkServed(input int n, input logic [23:0] e);
		int k;
		k = 0;
		while (served.size() < n && k < 200) begin
			@(posedge mclk);
			k++;
		end
		// Extra cycles so a spurious late entry is also seen
		repeat (20) @(posedge mclk);
		compares++;
		if (served.size() != n) miss($sformatf("%0d served", served.size()));
		else for (int i = 0; i < n; i++) begin
			if (served[i] !== e[6*i+:6]) miss($sformatf("vector %h", served[i]));
		end
		served.delete();
	endtask
	task automatic wbXfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk);
		wbCyc <= 1'b1;
		wbWe <= w;
		wbAdr <= {24'h0, a};
		wbDatW <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbWe <= 1'b0;
		if (n >= 20) miss("no bus answer");
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbXfer(1'b1, a, d, q);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wbXfer(1'b0, a, 32'h0, q);
		chkReg(q, exp, "read");
	endtask
	task automatic fire(input logic [63:0] m);
		@(posedge mclk);
		irqPins <= m[47:0];
		flt <= m[54:48];
		@(posedge mclk);
		irqPins <= '0;
		flt <= '0;
		if (m[57:56] != 2'b00) wrReg(8'h00, {28'h0, 2'b11, m[57:56]});
	endtask
	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge mclk);
		miss("watchdog");
		stop_test();
	end
	initial begin
		{mclk, rst, wbCyc, wbWe, wbAdr, wbDatW, irqPins, flt} = {2'b01, 121'h0};
		repeat (6) @(posedge mclk);
		chkReg({26'h0, vecNum}, 32'h0, "reset vector");
		rst <= 1'b0;
		for (int k = 0; k < 50 && activeLvl !== 5'h1f; k++) @(posedge mclk);
		chkReg({27'h0, activeLvl}, 32'h1f, "base level");
		rdChk(8'h08, 32'h0);
		rdChk(8'h20, 32'h0);
		wrReg(8'h10, 32'hffff_ffff);
		wrReg(8'h14, 32'hffff_ffff);
		rdChk(8'h10, 32'h3ffc_1cff);
		rdChk(8'h14, 32'h0);
		wrReg(8'h00, 32'hc);
		$display("test reset done");
		for (int i = 0; i < NROW; i++) begin
			fire(64'h1 << rowSrc[i]);
			chkServed(1, {18'h0, rowVec[i]});
		end
		$display("test vectors done");
		wrReg(8'h20, 32'h2000);
		restoreCnt = 0;
		fire(64'h1b);
		chkServed(4, {6'h13, 6'h14, 6'h11, 6'h10});
		chkReg(32'(restoreCnt), 32'h1, "restores");
		wrReg(8'h08, 32'h0100_3000);
		fire((64'h1 << 52) | (64'h1 << 54));
		chkServed(2, {12'h0, 6'h0b, 6'h0f});
		fire((64'h1 << 8) | (64'h1 << 30) | (64'h1 << 47));
		chkServed(0, 24'h0);
		wrReg(8'h00, 32'h0);
		fire((64'h1 << 49) | (64'h1 << 53));
		chkServed(1, 24'h3);
		wrReg(8'h08, 32'h0000_0100);
		wrReg(8'h00, 32'h10);
		fire(64'h1 << 51);
		fire(64'h1 << 48);
		chkServed(2, {12'h0, 6'h03, 6'h06});
		wrReg(8'hfc, 32'hffff_ffff);
		rdChk(8'hfc, 32'h0);
		$display("test awkward cases done");
		stop_test();
	end
endmodule // exception_priority_vector_map_test
